/* File: include/mode_select_consts.svh */
// strap codes and timing constants for the port and management mode select block
`ifndef MODE_SELECT_CONSTS_SVH
`define MODE_SELECT_CONSTS_SVH
`define P0_CODE_MAC      3'h0
`define P0_CODE_PHY_LO   3'h1
`define P0_CODE_PHY_HI   3'h6
`define MGMT_CODE_EXT    2'h1
`define MGMT_CODE_TWI    2'h2
`define ROLE_CODE_MII_LO 3'h1
`define ROLE_CODE_MII_HI 3'h3
`define ROLE_CODE_RMII_LO 3'h4
`define ROLE_CODE_RMII_HI 3'h6
`define ROLE_CODE_INT    3'h7
`define SETTLE_NS        200
`define CLK_PERIOD_NS    50
`define SETTLE_CYCLES    ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: include/mode_select_pkg.sv */
// types for the port and management mode select block
package mode_select_pkg;
	typedef enum logic [1:0] {
		role_mac,
		role_phy_mii,
		role_phy_rmii,
		role_internal
	} port_role_e;
	typedef enum logic [1:0] {
		mgmt_reserved,
		mgmt_ext_slave,
		mgmt_twi_slave
	} mgmt_mode_e;
	typedef enum logic [1:0] {
		rate_10,
		rate_100,
		rate_200
	} rate_e;
endpackage

/* File: logic/port_mode_select.sv */
// strap capture and decode of port roles and management paths
// How it works
// [RULE_01] port 0 and port 1 each may take MAC role toward an external PHY, independently.
// [RULE_02] a MAC-role port allows 10, 100 and 200 Mbps, 200 being turbo.
// [RULE_03] each port may take PHY role toward an external MAC over MII or RMII, independently.
// [RULE_04] a PHY-role port on MII allows 10, 100 and 200 Mbps.
// [RULE_05] a PHY-role port on RMII allows only 10 and 100 Mbps, never turbo.
// [RULE_06] two-wire management makes the device a two-wire slave for CPU register access.
// [RULE_07] the two-wire slave and the EEPROM master share one pair of pins and take turns.
// [RULE_08] the EEPROM master loads configuration and serves CPU EEPROM access in every mode.
// [RULE_09] the extended slave maps PHYs to normal addresses and other registers to 16 to 31.
// [RULE_10] the plain management slave exposes only the two internal PHY register sets.
// [RULE_11] MAC role with two-wire management makes the device a management master.
// [RULE_12] a virtual PHY register set is reachable by the external MAC over management pins.
// [RULE_13] straps are sampled at startup; port-0 000 is MAC, management 01 extended, 10 two-wire.
// [RULE_14] port-0 codes 001 to 110 are PHY role and choose the slave's register reach.
// [RULE_15] port-1 role never changes the management mode.
// [RULE_16] port 1 role comes from its own 3-bit strap.
// [RULE_17] port-0 111 and management 00 or 11 are reserved.
`timescale 1ns/1ns
`default_nettype none
`include "mode_select_consts.svh"
module port_mode_select (
	input  wire logic                        i_mclk,
	input  wire logic                        i_srst,
	input  wire logic [2:0]                  i_port0_role_strap,
	input  wire logic [2:0]                  i_port1_role_strap,
	input  wire logic                        i_mgmt_select_high_strap,
	input  wire logic                        i_mgmt_select_low_strap,
	input  wire logic                        i_eeprom_req,
	input  wire logic                        i_twi_slave_busy,
	output var  logic                        o_straps_valid,
	output var  mode_select_pkg::port_role_e o_port0_role,
	output var  mode_select_pkg::port_role_e o_port1_role,
	output var  mode_select_pkg::rate_e      o_port0_max_rate,
	output var  mode_select_pkg::rate_e      o_port1_max_rate,
	output var  mode_select_pkg::mgmt_mode_e o_mgmt_mode,
	output var  logic                        o_twi_slave_en,
	output var  logic                        o_ext_slave_en,
	output var  logic                        o_ext_slave_upper_map,
	output var  logic                        o_plain_slave_en,
	output var  logic                        o_mdio_master_en,
	output var  logic                        o_vphy_slave_en,
	output var  logic                        o_vphy_in_ext_map,
	output var  logic                        o_eeprom_master_en,
	output var  logic                        o_eeprom_grant,
	output var  logic                        o_reserved_mode
);
	import mode_select_pkg::*;

	localparam int unsigned settle_cnt = `SETTLE_CYCLES;

	// port role decode shared by both ports
	function automatic port_role_e role_of(input logic [2:0] code, input logic allow_int);
		if (code == `P0_CODE_MAC) begin
			role_of = role_mac; // see [RULE_01]
		end else if (code >= `ROLE_CODE_MII_LO && code <= `ROLE_CODE_MII_HI) begin
			role_of = role_phy_mii; // see [RULE_03]
		end else if (code >= `ROLE_CODE_RMII_LO && code <= `ROLE_CODE_RMII_HI) begin
			role_of = role_phy_rmii; // see [RULE_03]
		end else if (allow_int) begin
			role_of = role_internal;
		end else begin
			role_of = role_mac; // reserved code, undefined by design
		end
	endfunction

	// fastest rate each role may run
	function automatic rate_e rate_of(input port_role_e r);
		case (r)
			role_mac:      rate_of = rate_200; // see [RULE_02]
			role_phy_mii:  rate_of = rate_200; // see [RULE_04]
			default:       rate_of = rate_100; // see [RULE_05]
		endcase
	endfunction

	// strap sampling: wait a few cycles after reset so straps are stable, then latch once
	logic [3:0]  settle_reg;
	logic [3:0]  settle_next;
	logic        valid_reg;
	logic        valid_next;
	logic [2:0]  p0_reg;
	logic [2:0]  p0_next;
	logic [2:0]  p1_reg;
	logic [2:0]  p1_next;
	logic [1:0]  mg_reg;
	logic [1:0]  mg_next;

	always_comb begin
		settle_next = settle_reg;
		valid_next  = valid_reg;
		p0_next     = p0_reg;
		p1_next     = p1_reg;
		mg_next     = mg_reg;
		if (!valid_reg) begin
			if (settle_reg == 4'(settle_cnt - 1)) begin
				valid_next = 1'b1; // see [RULE_13]
				p0_next    = i_port0_role_strap;
				p1_next    = i_port1_role_strap; // see [RULE_16]
				mg_next    = {i_mgmt_select_high_strap, i_mgmt_select_low_strap};
			end else begin
				settle_next = settle_reg + 4'h1;
			end
		end
	end

	// capture registers; straps are frozen once latched
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			settle_reg <= 4'h0;
			valid_reg  <= 1'b0;
			p0_reg     <= 3'h0;
			p1_reg     <= 3'h0;
			mg_reg     <= 2'h0;
		end else begin
			settle_reg <= settle_next;
			valid_reg  <= valid_next;
			p0_reg     <= p0_next;
			p1_reg     <= p1_next;
			mg_reg     <= mg_next;
		end
	end

	// mode decode from latched straps; port 1 never enters the management terms
	port_role_e r0;
	port_role_e r1;
	logic       p0_mac;
	logic       p0_phy;
	logic       m_ext;
	logic       m_twi;
	logic       resv;
	logic       live;
	logic       straps_valid_next;
	port_role_e port0_role_next;
	port_role_e port1_role_next;
	rate_e      port0_rate_next;
	rate_e      port1_rate_next;
	mgmt_mode_e mgmt_mode_next;
	logic       twi_slave_next;
	logic       ext_slave_next;
	logic       upper_map_next;
	logic       plain_slave_next;
	logic       mdio_master_next;
	logic       vphy_slave_next;
	logic       vphy_ext_next;
	logic       eeprom_master_next;
	logic       reserved_next;

	always_comb begin
		r0     = role_of(p0_reg, 1'b0);
		r1     = role_of(p1_reg, 1'b1); // see [RULE_15]
		p0_mac = (p0_reg == `P0_CODE_MAC);
		p0_phy = (p0_reg >= `P0_CODE_PHY_LO) && (p0_reg <= `P0_CODE_PHY_HI); // see [RULE_14]
		m_ext  = (mg_reg == `MGMT_CODE_EXT);
		m_twi  = (mg_reg == `MGMT_CODE_TWI);
		resv   = !(p0_mac || p0_phy) || !(m_ext || m_twi); // see [RULE_17]
		live   = valid_reg && !resv; // no slave or master enable other than the eeprom master is on before the straps are latched
		straps_valid_next  = valid_reg;
		port0_role_next    = r0;
		port1_role_next    = r1;
		port0_rate_next    = rate_of(r0);
		port1_rate_next    = rate_of(r1);
		mgmt_mode_next     = resv ? mgmt_reserved : (m_ext ? mgmt_ext_slave : mgmt_twi_slave);
		twi_slave_next     = live && m_twi; // see [RULE_06]
		ext_slave_next     = live && m_ext; // see [RULE_09]
		upper_map_next     = live && m_ext; // see [RULE_09]
		plain_slave_next   = 1'b0; // see [RULE_10] no listed strap selects plain slave
		mdio_master_next   = live && p0_mac && m_twi; // see [RULE_11]
		vphy_slave_next    = live && p0_phy && m_twi; // see [RULE_12]
		vphy_ext_next      = live && p0_phy && m_ext; // see [RULE_14]
		eeprom_master_next = 1'b1; // see [RULE_08]
		reserved_next      = valid_reg && resv; // see [RULE_17]
	end

	// two-wire pin arbitration: eeprom master holds the pins until released, slave otherwise
	logic grant_reg;
	logic grant_next;

	always_comb begin
		grant_next = grant_reg;
		if (!valid_reg) begin
			grant_next = 1'b1; // initial load owns the pins, see [RULE_08]
		end else if (grant_reg && !i_eeprom_req) begin
			grant_next = 1'b0; // see [RULE_07]
		end else if (!grant_reg && i_eeprom_req && !i_twi_slave_busy) begin
			grant_next = 1'b1; // see [RULE_07]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			grant_reg <= 1'b0;
		end else begin
			grant_reg <= grant_next;
		end
	end

	// registered outputs
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_straps_valid        <= 1'b0;
			o_port0_role          <= role_mac;
			o_port1_role          <= role_mac;
			o_port0_max_rate      <= rate_10;
			o_port1_max_rate      <= rate_10;
			o_mgmt_mode           <= mgmt_reserved;
			o_twi_slave_en        <= 1'b0;
			o_ext_slave_en        <= 1'b0;
			o_ext_slave_upper_map <= 1'b0;
			o_plain_slave_en      <= 1'b0;
			o_mdio_master_en      <= 1'b0;
			o_vphy_slave_en       <= 1'b0;
			o_vphy_in_ext_map     <= 1'b0;
			o_eeprom_master_en    <= 1'b0;
			o_eeprom_grant        <= 1'b0;
			o_reserved_mode       <= 1'b0;
		end else begin
			o_straps_valid        <= straps_valid_next;
			o_port0_role          <= port0_role_next;
			o_port1_role          <= port1_role_next;
			o_port0_max_rate      <= port0_rate_next;
			o_port1_max_rate      <= port1_rate_next;
			o_mgmt_mode           <= mgmt_mode_next;
			o_twi_slave_en        <= twi_slave_next;
			o_ext_slave_en        <= ext_slave_next;
			o_ext_slave_upper_map <= upper_map_next;
			o_plain_slave_en      <= plain_slave_next;
			o_mdio_master_en      <= mdio_master_next;
			o_vphy_slave_en       <= vphy_slave_next;
			o_vphy_in_ext_map     <= vphy_ext_next;
			o_eeprom_master_en    <= eeprom_master_next;
			o_eeprom_grant        <= grant_next;
			o_reserved_mode       <= reserved_next;
		end
	end

	// the eeprom master never takes the pins while the two-wire slave is busy
	a_twi_share_excl: assert property (@(posedge i_mclk) disable iff (i_srst) // see [RULE_07]
		o_eeprom_grant && o_twi_slave_en |-> !i_twi_slave_busy || $past(o_eeprom_grant))
		else $error("pin grant taken while slave busy");

	// mac plus two-wire yields master and no extended slave
	a_mac_twi_master: assert property (@(posedge i_mclk) disable iff (i_srst) // see [RULE_11]
		valid_reg && p0_reg == 3'h0 && mg_reg == 2'h2 |=> o_mdio_master_en && !o_ext_slave_en)
		else $error("mac two-wire mode not decoded");

	// port-0 rmii never turbo
	a_rmii_rate: assert property (@(posedge i_mclk) disable iff (i_srst) // see [RULE_05]
		o_port0_role == role_phy_rmii |-> o_port0_max_rate == rate_100)
		else $error("rmii port allowed turbo");

	// port 1 strap change does not move the management mode output
	a_p1_indep: assert property (@(posedge i_mclk) disable iff (i_srst) // see [RULE_15]
		valid_reg && $stable(p0_reg) && $stable(mg_reg) |=> $stable(o_mgmt_mode))
		else $error("management moved with port 1");

	// straps latch after the settle window
	sequence s_settled;
		!valid_reg ##1 valid_reg;
	endsequence
	a_strap_latch: assert property (@(posedge i_mclk) disable iff (i_srst) // see [RULE_13]
		s_settled |=> o_straps_valid)
		else $error("strap valid not shown");

	// extended slave exposes upper map
	a_ext_map: assert property (@(posedge i_mclk) disable iff (i_srst) // see [RULE_09]
		o_ext_slave_en |-> o_ext_slave_upper_map && o_mgmt_mode == mgmt_ext_slave)
		else $error("extended map missing");

	// phy two-wire gives virtual phy slave
	a_vphy_twi: assert property (@(posedge i_mclk) disable iff (i_srst) // see [RULE_12]
		valid_reg && p0_reg == 3'h3 && mg_reg == 2'h2 |=> o_vphy_slave_en && o_twi_slave_en)
		else $error("virtual phy slave not enabled");

	// eeprom master always present after reset
	a_eeprom_on: assert property (@(posedge i_mclk) disable iff (i_srst) // see [RULE_08]
		o_straps_valid |-> o_eeprom_master_en)
		else $error("eeprom master off");
endmodule // port_mode_select
`default_nettype wire

/* File: testbench/twi_cpu_model.sv */
// cpu-side model that runs slave traffic on the shared two-wire pins
`timescale 1ns/1ns
`default_nettype none
module twi_cpu_model (
	input  wire logic i_mclk,
	input  wire logic i_start,
	input  wire logic i_grant,
	output wire logic o_busy
);
	logic [3:0] left = 4'h0;
	// a transfer opens only while the eeprom master holds no grant
	always @(posedge i_mclk) begin
		if (left != 4'h0) begin
			left <= left - 4'h1;
		end else if (i_start && !i_grant) begin
			left <= 4'h6;
		end
	end
	assign o_busy = (left != 4'h0); // busy spans the whole transfer
endmodule // twi_cpu_model
`default_nettype wire

/* File: testbench/tb_port_mode_select.sv */
// self-checking bench for the port and management mode select block
`timescale 1ns/1ns
`default_nettype none
module tb_port_mode_select;
	import mode_select_pkg::*;
	logic       mclk = 1'b0, srst = 1'b1, mg_hi = 1'b0, mg_lo = 1'b0;
	logic       req = 1'b1, start = 1'b0, busy, valid, gnt, rsv, eem;
	logic       twi, ext, upm, pln, mst, vph, vpx;
	logic [2:0] s0 = 3'h0, s1 = 3'h0;
	port_role_e p0r, p1r;
	rate_e      p0m, p1m;
	mgmt_mode_e mm;
	int         errors = 0, checked = 0;
	always #25 mclk = ~mclk;
	port_mode_select i_dut (.i_mclk(mclk), .i_srst(srst), .i_port0_role_strap(s0),
		.i_port1_role_strap(s1), .i_mgmt_select_high_strap(mg_hi),
		.i_mgmt_select_low_strap(mg_lo), .i_eeprom_req(req), .i_twi_slave_busy(busy),
		.o_straps_valid(valid), .o_port0_role(p0r), .o_port1_role(p1r),
		.o_port0_max_rate(p0m), .o_port1_max_rate(p1m), .o_mgmt_mode(mm),
		.o_twi_slave_en(twi), .o_ext_slave_en(ext), .o_ext_slave_upper_map(upm),
		.o_plain_slave_en(pln), .o_mdio_master_en(mst), .o_vphy_slave_en(vph),
		.o_vphy_in_ext_map(vpx), .o_eeprom_master_en(eem), .o_eeprom_grant(gnt),
		.o_reserved_mode(rsv));
	twi_cpu_model i_cpu (.i_mclk(mclk), .i_start(start), .i_grant(gnt), .o_busy(busy));
	task automatic cmp1(input logic got, input logic exp, input string m);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic cmp2(input logic [1:0] got, input logic [1:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	// strap code to role; code 7 is internal only on port 1
	function automatic logic [1:0] role_of(input logic [2:0] c, input logic p1);
		if (c == 3'h0) return 2'h0;
		if (c <= 3'h3) return 2'h1;
		if (c <= 3'h6) return 2'h2;
		return p1 ? 2'h3 : 2'h0;
	endfunction
	// turbo only on mac and mii roles
	function automatic logic [1:0] rate_of(input logic [1:0] r);
		return (r <= 2'h1) ? 2'h2 : 2'h1;
	endfunction
	task automatic check_all(input logic [2:0] c0, input logic [2:0] c1, input logic [1:0] mg);
		logic rs;
		logic phy;
		rs = (c0 == 3'h7) || (mg == 2'h0) || (mg == 2'h3);
		phy = (c0 != 3'h0) && (c0 != 3'h7);
		cmp2(p0r, role_of(c0, 1'b0), "port0 role");
		cmp2(p1r, role_of(c1, 1'b1), "port1 role");
		cmp2(p0m, rate_of(role_of(c0, 1'b0)), "port0 rate");
		cmp2(p1m, rate_of(role_of(c1, 1'b1)), "port1 rate");
		cmp1(rsv, rs, "reserved flag");
		cmp1(eem, 1'b1, "eeprom master");
		cmp1(pln, 1'b0, "plain slave");
		cmp1(ext, !rs && mg == 2'h1, "ext slave");
		cmp1(upm, !rs && mg == 2'h1, "upper map");
		cmp1(twi, !rs && mg == 2'h2, "twi slave");
		cmp1(mst, !rs && mg == 2'h2 && !phy, "mgmt master");
		cmp1(vpx, !rs && mg == 2'h1 && phy, "vphy in map");
		cmp2(mm, rs ? 2'h0 : mg, "mgmt mode");
		cmp1(vph, !rs && mg == 2'h2 && phy, "virtual phy");
	endtask
	// reset with given straps, then scramble them to prove they were latched
	task automatic run_mode(input logic [2:0] c0, input logic [2:0] c1, input logic [1:0] mg);
		int n;
		n = 0;
		@(posedge mclk);
		srst <= 1'b1;
		s0 <= c0;
		s1 <= c1;
		{mg_hi, mg_lo} <= mg;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		while (valid !== 1'b1 && n < 20) begin
			@(negedge mclk);
			n++;
		end
		cmp1(valid, 1'b1, "straps valid");
		@(posedge mclk);
		s0 <= ~c0;
		s1 <= ~c1;
		{mg_hi, mg_lo} <= ~mg;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		check_all(c0, c1, mg);
	endtask
	// eeprom master waits while the cpu transfer is in flight
	task automatic arb_check();
		int n;
		n = 0;
		@(posedge mclk);
		req <= 1'b0;
		@(posedge mclk);
		@(negedge mclk);
		cmp1(gnt, 1'b0, "grant release");
		@(posedge mclk);
		start <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
		req <= 1'b1;
		repeat (4) begin
			@(negedge mclk);
			cmp1(gnt, 1'b0, "grant while busy");
		end
		while (gnt !== 1'b1 && n < 10) begin
			@(negedge mclk);
			n++;
		end
		cmp1(gnt, 1'b1, "grant after idle");
		cmp1(busy, 1'b0, "bus idle at grant");
	endtask
	task give_verdict();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(49));
		for (int i = 0; i < 32; i++) run_mode(i[4:2], i[2:0], i[1:0]);
		for (int i = 0; i < 20; i++) run_mode(3'($urandom), 3'($urandom), 2'($urandom));
		// arbitrate in mac two-wire mode so the slave enable is up while pins change hands
		run_mode(3'h0, 3'h0, 2'h2);
		arb_check();
		give_verdict();
	end
	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#(4000 * 50);
		errors++;
		give_verdict();
	end
endmodule // tb_port_mode_select
`default_nettype wire
